/* File: shared/rpam_pkg.sv */
package rpam_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned BIT_RATE_HZ = 10_000_000;
  localparam int unsigned BIT_CLKS = SYS_CLK_HZ / BIT_RATE_HZ; // cycles per bit time
  localparam int unsigned CRT_BITS = 16; // carrier recovery time, bit times
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACT_LEN = 8'h08;
  localparam logic [7:0] OFS_TALLY = 8'h0C;
  localparam logic [7:0] OFS_ADDR_LO = 8'h10;
  localparam logic [7:0] OFS_ADDR_HI = 8'h14;
  localparam logic [7:0] OFS_EVT_CNT = 8'h18;
  localparam logic [7:0] OFS_FCS_CNT = 8'h1C;
  localparam logic [7:0] OFS_OCT_TOT = 8'h20;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ADMIN_BIT = 0;
  localparam int unsigned CTRL_PORT_LSB = 8;
  localparam int unsigned ST_CARRIER_BIT = 0;
  localparam int unsigned ST_COLL_BIT = 1;
  localparam int unsigned ST_FCS_BIT = 2;
  localparam int unsigned ST_ALIGN_BIT = 3;
  localparam int unsigned ST_SA_VALID_BIT = 4;
  localparam int unsigned ST_PORT_LSB = 8;
  localparam int unsigned ADDR_HI_VALID_BIT = 31;
  // ----------------------------------------------------------------
  // reset values and check constants
  // ----------------------------------------------------------------
  localparam logic RST_ADMIN = 1'b0;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY_REFL = 32'hEDB8_8320;
  localparam logic [31:0] CRC_GOOD_RESIDUE = 32'hDEBB_20E3;
  localparam int unsigned FCS_OCTETS = 4;
  localparam int unsigned SA_FIRST_IDX = 6; // zero-based index of octet seven
  localparam int unsigned SA_LAST_IDX = 11;
  // framer states, gray along idle -> hunt -> data
  typedef enum logic [1:0] {
    RPAM_FR_IDLE = 2'b00,
    RPAM_FR_HUNT = 2'b01,
    RPAM_FR_DATA = 2'b11
  } rpam_fr_state_t;
endpackage

/* File: verilog/rpam_port_monitor.sv */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
// How it works
// - time carrier flag assertion in bit times
// - subtract recovery time from measured length
// - raise carrier on idle exit, remember port
// - drop carrier after quiet recovery time
// - collision flag set by signal quality error
// - collision flag held until next carrier
// - last four octets checked as frame check
// - frame check fail cleared on next carrier
// - framer takes bits only under carrier
// - strip preamble and delimiter, build octets
// - flag leftover bits as octet misalignment
// - misalignment cleared on next carrier
// - count complete octets into tally
// - tally zeroed on next carrier
// - octets seven to twelve form sender address
// - sender address invalid on next carrier
// - admin setting restored after power loss
// - statistics counters wrap, cleared only by reset
module rpam_port_monitor #(
  parameter int unsigned PORT_W = 4,
  parameter int unsigned LEN_W = 32,
  parameter int unsigned TALLY_W = 16
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // repeater core
  input wire logic I_REP_LEAVE_IDLE,
  input wire logic [PORT_W-1:0] I_REP_ACTIVE_PORT,
  // port pma
  input wire logic I_PORT_INPUT_SYMBOL_IDLE,
  input wire logic I_PORT_COLLISION_INPUT_SQE,
  input wire logic I_RX_BIT_VALID,
  input wire logic I_RX_BIT,
  // non-volatile admin store
  input wire logic I_ADMIN_RESTORE,
  output logic O_ADMIN_STORE_WR,
  output logic O_ADMIN_STORE_DATA,
  // results
  output logic O_CARRIER_ACTIVITY_FLAG,
  output logic O_COLLISION_FLAG,
  output logic [LEN_W-1:0] O_ACTIVITY_LENGTH_BITS,
  output logic O_FRAME_CHECK_FAIL,
  output logic O_OCTET_MISALIGN_FLAG,
  output logic [TALLY_W-1:0] O_COMPLETE_OCTET_TALLY,
  output logic [47:0] O_SENDER_ADDRESS_FIELD,
  output logic O_SENDER_ADDRESS_VALID
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W = $clog2(rpam_pkg::BIT_CLKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(rpam_pkg::BIT_CLKS - 1);
  localparam logic [LEN_W-1:0] CRT_LEN = LEN_W'(rpam_pkg::CRT_BITS);
  logic [DIV_W-1:0] div_q;
  logic bit_tick;
  logic admin_q, restored_q;
  logic [PORT_W-1:0] port_id_q, port_sel_q;
  logic carrier_set, carrier_drop;
  logic [LEN_W-1:0] act_cnt_q, quiet_cnt_q;
  rpam_pkg::rpam_fr_state_t fr_q;
  logic prev_bit_q;
  logic [7:0] oct_sr_q;
  logic [2:0] bit_cnt_q;
  logic [31:0] crc_q, crc_oct_q;
  logic [31:0] evt_cnt_q, fcs_cnt_q, oct_tot_q;
  logic octet_done;
  logic [7:0] octet_val;
  logic [31:0] crc_next;
  logic [31:0] rd_d;
  logic addr_ok;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? rpam_pkg::CRC_POLY_REFL : 32'h0000_0000);
  endfunction

  // ----------------------------------------------------------------
  // bit time divider
  // ----------------------------------------------------------------
  // one enable per bit time, free running so timing needs no pin clock
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      div_q <= '0;
    end else begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
    end
  end
  assign bit_tick = (div_q == DIV_LAST);

  // ----------------------------------------------------------------
  // admin setting, restored from non-volatile store after reset
  // ----------------------------------------------------------------
  // async reset loads a constant; the stored level is caught one clock later
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      admin_q <= rpam_pkg::RST_ADMIN;
      restored_q <= 1'b0;
      O_ADMIN_STORE_WR <= 1'b0;
      O_ADMIN_STORE_DATA <= rpam_pkg::RST_ADMIN;
      port_id_q <= '0;
    end else begin
      O_ADMIN_STORE_WR <= 1'b0;
      if (!restored_q) begin
        admin_q <= I_ADMIN_RESTORE;
        restored_q <= 1'b1;
      end else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == rpam_pkg::OFS_CTRL) begin
        admin_q <= I_PWDATA[rpam_pkg::CTRL_ADMIN_BIT];
        port_id_q <= I_PWDATA[rpam_pkg::CTRL_PORT_LSB +: PORT_W];
        O_ADMIN_STORE_WR <= 1'b1; // every change goes to the store
        O_ADMIN_STORE_DATA <= I_PWDATA[rpam_pkg::CTRL_ADMIN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // carrier, collision and activity timing
  // ----------------------------------------------------------------
  assign carrier_set = I_REP_LEAVE_IDLE && admin_q && !O_CARRIER_ACTIVITY_FLAG
                       && I_REP_ACTIVE_PORT == port_id_q;
  // one tick more than the recovery time, since the first quiet tick may come after one clock
  assign carrier_drop = O_CARRIER_ACTIVITY_FLAG && bit_tick && quiet_cnt_q == CRT_LEN;

  // carrier flag with quiet-time recovery
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CARRIER_ACTIVITY_FLAG <= 1'b0;
      port_sel_q <= '0;
      quiet_cnt_q <= '0;
    end else begin
      if (carrier_set) begin
        O_CARRIER_ACTIVITY_FLAG <= 1'b1;
        port_sel_q <= I_REP_ACTIVE_PORT;
        quiet_cnt_q <= '0;
      end else if (carrier_drop) begin
        O_CARRIER_ACTIVITY_FLAG <= 1'b0;
        quiet_cnt_q <= '0;
      end else if (!I_PORT_INPUT_SYMBOL_IDLE || I_PORT_COLLISION_INPUT_SQE) begin
        quiet_cnt_q <= '0; // any activity restarts the quiet window
      end else if (O_CARRIER_ACTIVITY_FLAG && bit_tick) begin
        quiet_cnt_q <= quiet_cnt_q + LEN_W'(1);
      end
    end
  end

  // collision: a new sqe in the clearing cycle wins
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_COLLISION_FLAG <= 1'b0;
    end else if (I_PORT_COLLISION_INPUT_SQE) begin
      O_COLLISION_FLAG <= 1'b1;
    end else if (carrier_set) begin
      O_COLLISION_FLAG <= 1'b0;
    end
  end

  // activity timer; recovery time removed, floored at zero
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      act_cnt_q <= '0;
      O_ACTIVITY_LENGTH_BITS <= '0;
    end else if (carrier_set) begin
      act_cnt_q <= '0;
    end else if (carrier_drop) begin
      O_ACTIVITY_LENGTH_BITS <= (act_cnt_q + LEN_W'(1) > CRT_LEN) ?
                                act_cnt_q + LEN_W'(1) - CRT_LEN : '0;
    end else if (O_CARRIER_ACTIVITY_FLAG && bit_tick) begin
      act_cnt_q <= act_cnt_q + LEN_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // framer, crc, tally and sender address
  // ----------------------------------------------------------------
  assign crc_next = crc_step(crc_q, I_RX_BIT);
  assign octet_val = {I_RX_BIT, oct_sr_q[7:1]};
  assign octet_done = O_CARRIER_ACTIVITY_FLAG && I_RX_BIT_VALID && fr_q == rpam_pkg::RPAM_FR_DATA
                      && bit_cnt_q == 3'd7;

  // sfd ends on the first pair of ones; bits arrive lsb first
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fr_q <= rpam_pkg::RPAM_FR_IDLE;
      prev_bit_q <= 1'b0;
      oct_sr_q <= '0;
      bit_cnt_q <= '0;
      crc_q <= rpam_pkg::CRC_INIT;
      crc_oct_q <= rpam_pkg::CRC_INIT;
    end else if (carrier_set) begin
      fr_q <= rpam_pkg::RPAM_FR_HUNT;
      prev_bit_q <= 1'b0;
      bit_cnt_q <= '0;
      crc_q <= rpam_pkg::CRC_INIT;
      crc_oct_q <= rpam_pkg::CRC_INIT;
    end else if (carrier_drop) begin
      fr_q <= rpam_pkg::RPAM_FR_IDLE;
    end else if (O_CARRIER_ACTIVITY_FLAG && I_RX_BIT_VALID) begin
      case (fr_q)
        rpam_pkg::RPAM_FR_HUNT: begin
          prev_bit_q <= I_RX_BIT;
          if (prev_bit_q && I_RX_BIT) begin
            fr_q <= rpam_pkg::RPAM_FR_DATA; // preamble and delimiter dropped
          end
        end
        rpam_pkg::RPAM_FR_DATA: begin
          oct_sr_q <= octet_val;
          bit_cnt_q <= bit_cnt_q + 3'd1;
          crc_q <= crc_next;
          if (bit_cnt_q == 3'd7) begin
            crc_oct_q <= crc_next; // residue over whole octets only
          end
        end
        default: begin
          fr_q <= rpam_pkg::RPAM_FR_IDLE;
        end
      endcase
    end
  end

  // per-event results; all but the address field cleared when the next event starts
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_COMPLETE_OCTET_TALLY <= '0;
      O_SENDER_ADDRESS_FIELD <= '0;
      O_SENDER_ADDRESS_VALID <= 1'b0;
      O_FRAME_CHECK_FAIL <= 1'b0;
      O_OCTET_MISALIGN_FLAG <= 1'b0;
    end else if (carrier_set) begin
      O_COMPLETE_OCTET_TALLY <= '0;
      O_SENDER_ADDRESS_VALID <= 1'b0;
      O_FRAME_CHECK_FAIL <= 1'b0;
      O_OCTET_MISALIGN_FLAG <= 1'b0;
    end else if (carrier_drop) begin
      // frames shorter than the check field cannot pass
      O_FRAME_CHECK_FAIL <= crc_oct_q != rpam_pkg::CRC_GOOD_RESIDUE
                            || O_COMPLETE_OCTET_TALLY < TALLY_W'(rpam_pkg::FCS_OCTETS);
      O_OCTET_MISALIGN_FLAG <= fr_q == rpam_pkg::RPAM_FR_DATA && bit_cnt_q != 3'd0;
    end else if (octet_done) begin
      O_COMPLETE_OCTET_TALLY <= O_COMPLETE_OCTET_TALLY + TALLY_W'(1);
      if (O_COMPLETE_OCTET_TALLY >= TALLY_W'(rpam_pkg::SA_FIRST_IDX)
          && O_COMPLETE_OCTET_TALLY <= TALLY_W'(rpam_pkg::SA_LAST_IDX)) begin
        O_SENDER_ADDRESS_FIELD <= {O_SENDER_ADDRESS_FIELD[39:0], octet_val};
      end
      if (O_COMPLETE_OCTET_TALLY == TALLY_W'(rpam_pkg::SA_LAST_IDX)) begin
        O_SENDER_ADDRESS_VALID <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // wrapping statistics counters
  // ----------------------------------------------------------------
  // no clear path: software reads often enough to catch the wrap
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evt_cnt_q <= '0;
      fcs_cnt_q <= '0;
      oct_tot_q <= '0;
    end else begin
      if (carrier_set) begin
        evt_cnt_q <= evt_cnt_q + 32'd1;
      end
      if (carrier_drop && (crc_oct_q != rpam_pkg::CRC_GOOD_RESIDUE
          || O_COMPLETE_OCTET_TALLY < TALLY_W'(rpam_pkg::FCS_OCTETS))) begin
        fcs_cnt_q <= fcs_cnt_q + 32'd1;
      end
      if (octet_done) begin
        oct_tot_q <= oct_tot_q + 32'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave: read data prepared in setup, ready in access
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    addr_ok = 1'b1;
    case (I_PADDR)
      rpam_pkg::OFS_CTRL: begin
        rd_d[rpam_pkg::CTRL_ADMIN_BIT] = admin_q;
        rd_d[rpam_pkg::CTRL_PORT_LSB +: PORT_W] = port_id_q;
      end
      rpam_pkg::OFS_STATUS: begin
        rd_d[rpam_pkg::ST_CARRIER_BIT] = O_CARRIER_ACTIVITY_FLAG;
        rd_d[rpam_pkg::ST_COLL_BIT] = O_COLLISION_FLAG;
        rd_d[rpam_pkg::ST_FCS_BIT] = O_FRAME_CHECK_FAIL;
        rd_d[rpam_pkg::ST_ALIGN_BIT] = O_OCTET_MISALIGN_FLAG;
        rd_d[rpam_pkg::ST_SA_VALID_BIT] = O_SENDER_ADDRESS_VALID;
        rd_d[rpam_pkg::ST_PORT_LSB +: PORT_W] = port_sel_q;
      end
      rpam_pkg::OFS_ACT_LEN: rd_d = 32'(O_ACTIVITY_LENGTH_BITS);
      rpam_pkg::OFS_TALLY: rd_d = 32'(O_COMPLETE_OCTET_TALLY);
      rpam_pkg::OFS_ADDR_LO: rd_d = O_SENDER_ADDRESS_FIELD[31:0];
      rpam_pkg::OFS_ADDR_HI: begin
        rd_d[15:0] = O_SENDER_ADDRESS_FIELD[47:32];
        rd_d[rpam_pkg::ADDR_HI_VALID_BIT] = O_SENDER_ADDRESS_VALID;
      end
      rpam_pkg::OFS_EVT_CNT: rd_d = evt_cnt_q;
      rpam_pkg::OFS_FCS_CNT: rd_d = fcs_cnt_q;
      rpam_pkg::OFS_OCT_TOT: rd_d = oct_tot_q;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PRDATA <= '0;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_ok;
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        O_PRDATA <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  a_carrier_rise: assert property (carrier_set |=> O_CARRIER_ACTIVITY_FLAG
    && port_sel_q == $past(I_REP_ACTIVE_PORT))
    else $error("carrier flag not raised on idle exit");
  a_carrier_quiet: assert property ($fell(O_CARRIER_ACTIVITY_FLAG) |-> $past(quiet_cnt_q) == CRT_LEN)
    else $error("carrier dropped before recovery time");
  a_coll_set: assert property (I_PORT_COLLISION_INPUT_SQE |=> O_COLLISION_FLAG)
    else $error("collision flag missed sqe");
  a_coll_hold: assert property (O_COLLISION_FLAG && !carrier_set |=> O_COLLISION_FLAG)
    else $error("collision flag cleared early");
  a_len_adjust: assert property (carrier_drop && act_cnt_q >= CRT_LEN |=>
    O_ACTIVITY_LENGTH_BITS == $past(act_cnt_q) + LEN_W'(1) - CRT_LEN)
    else $error("activity length not adjusted");
  a_event_clear: assert property (carrier_set |=> O_COMPLETE_OCTET_TALLY == '0 && !O_FRAME_CHECK_FAIL
    && !O_OCTET_MISALIGN_FLAG && !O_SENDER_ADDRESS_VALID)
    else $error("per-event results not cleared");
  a_tally_step: assert property (octet_done && !carrier_set |=>
    O_COMPLETE_OCTET_TALLY == $past(O_COMPLETE_OCTET_TALLY) + TALLY_W'(1))
    else $error("tally did not advance");
  a_misalign: assert property (carrier_drop |=> O_OCTET_MISALIGN_FLAG
    == ($past(fr_q) == rpam_pkg::RPAM_FR_DATA && $past(bit_cnt_q) != 3'd0))
    else $error("misalignment flag wrong");
  a_sa_valid: assert property ($rose(O_SENDER_ADDRESS_VALID) |->
    $past(O_COMPLETE_OCTET_TALLY) == TALLY_W'(rpam_pkg::SA_LAST_IDX))
    else $error("address valid at wrong octet");
  // the clear at the start of an event is the one legal change while the flag is low
  a_no_bits_idle: assert property (!O_CARRIER_ACTIVITY_FLAG && !carrier_set |=>
    $stable(O_COMPLETE_OCTET_TALLY))
    else $error("octets counted without carrier");

  c_frame_good: cover property ($fell(O_CARRIER_ACTIVITY_FLAG) ##1 O_SENDER_ADDRESS_VALID && !O_FRAME_CHECK_FAIL);
  c_coll_event: cover property (O_CARRIER_ACTIVITY_FLAG && O_COLLISION_FLAG);
  c_misalign: cover property ($rose(O_OCTET_MISALIGN_FLAG));
endmodule

/* File: testbench/rpam_far_side_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// repeater core and port pma stand-in
// ----------------------------------------------------------------
module rpam_far_side_model (
  // clock
  input wire logic i_clk,
  // repeater core side
  output logic o_leave_idle,
  output logic [3:0] o_active_port,
  // pma side
  output logic o_symbol_idle,
  output logic o_sqe,
  output logic o_bit_valid,
  output logic o_bit
);
  // quiet line at start, nothing pending
  initial begin
    o_leave_idle = 1'b0;
    o_active_port = 4'h0;
    o_symbol_idle = 1'b1;
    o_sqe = 1'b0;
    o_bit_valid = 1'b0;
    o_bit = 1'b0;
  end
  // one-cycle idle exit; the port number is not held past the pulse
  task automatic leave_idle(input logic [3:0] port);
    o_leave_idle <= 1'b1;
    o_active_port <= port;
    o_symbol_idle <= 1'b0;
    @(posedge i_clk);
    o_leave_idle <= 1'b0;
    o_active_port <= ~port;
  endtask
  // lsb first, one strobe per bit time; data line shows junk between strobes
  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      o_bit_valid <= 1'b1;
      o_bit <= v[i];
      @(posedge i_clk);
      o_bit_valid <= 1'b0;
      o_bit <= ~v[i];
      repeat (rpam_pkg::BIT_CLKS - 1) @(posedge i_clk);
    end
  endtask
  // line condition: idle symbol and collision report
  task automatic line(input logic idle, input logic sqe);
    o_symbol_idle <= idle;
    o_sqe <= sqe;
  endtask
endmodule

/* File: testbench/test_repeater_port_activity_monitor.sv */
`timescale 1ns/100ps
module test_repeater_port_activity_monitor;
  // ----------------------------------------------------------------
  // stimulus and observed nets
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic admin_restore = 1'b1;
  logic [31:0] prdata, act_len, rd;
  logic pready, pslverr, store_wr, store_data, carrier, coll, fcs_fail, misalign, sa_valid, er;
  logic [15:0] tally;
  logic [47:0] sa;
  logic leave_idle, sym_idle, sqe, bit_valid, rx_bit;
  logic [3:0] act_port;
  logic [7:0] frm [0:31];
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_store = 0;
  // admin store pulses, one per control write
  always @(posedge sys_clk) begin
    if (store_wr === 1'b1) begin
      n_store <= n_store + 1;
    end
  end
  // 20 ns clock
  always #10 sys_clk = ~sys_clk;
  // hang guard, well past the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  rpam_port_monitor dut_u (.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_REP_LEAVE_IDLE(leave_idle), .I_REP_ACTIVE_PORT(act_port),
    .I_PORT_INPUT_SYMBOL_IDLE(sym_idle), .I_PORT_COLLISION_INPUT_SQE(sqe), .I_RX_BIT_VALID(bit_valid),
    .I_RX_BIT(rx_bit), .I_ADMIN_RESTORE(admin_restore), .O_ADMIN_STORE_WR(store_wr),
    .O_ADMIN_STORE_DATA(store_data), .O_CARRIER_ACTIVITY_FLAG(carrier), .O_COLLISION_FLAG(coll),
    .O_ACTIVITY_LENGTH_BITS(act_len), .O_FRAME_CHECK_FAIL(fcs_fail), .O_OCTET_MISALIGN_FLAG(misalign),
    .O_COMPLETE_OCTET_TALLY(tally), .O_SENDER_ADDRESS_FIELD(sa), .O_SENDER_ADDRESS_VALID(sa_valid));
  rpam_far_side_model p (.i_clk(sys_clk), .o_leave_idle(leave_idle), .o_active_port(act_port),
    .o_symbol_idle(sym_idle), .o_sqe(sqe), .o_bit_valid(bit_valid), .o_bit(rx_bit));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) begin
      n_mismatch++;
      $display("CHECK FAILED apb ready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd & m);
  endtask
  // own reflected crc over frm[0..n-1], complemented
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h00_0000, frm[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ rpam_pkg::CRC_POLY_REFL) : (c >> 1);
    end
    return ~c;
  endfunction
  // payload plus check octets, low octet of the check first
  task automatic build(input int nd, input logic bad);
    logic [31:0] c;
    for (int i = 0; i < nd; i++) frm[i] = 8'(i * 17 + 3);
    c = crc_of(nd);
    for (int i = 0; i < 4; i++) frm[nd + i] = c[8*i +: 8];
    frm[nd] = frm[nd] ^ {8{bad}};
  endtask
  // whole event on port 3; returns quiet-to-drop and total cycles
  task automatic run_event(input int nd, input int extra, input logic col, output int q, output int t);
    int t0;
    t0 = cyc;
    p.leave_idle(4'h3);
    repeat (7) p.send_bits(8'h55, 8);
    p.send_bits(8'hD5, 8);
    p.line(1'b0, col);
    for (int i = 0; i < nd + 4; i++) p.send_bits(frm[i], 8);
    if (extra > 0) p.send_bits(8'h05, extra);
    p.line(1'b1, 1'b0);
    q = 0;
    while (carrier !== 1'b0 && q < 500) begin
      @(posedge sys_clk);
      q++;
    end
    t = cyc - t0;
    @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_setup();
    rd_chk(rpam_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0001, "admin restored");
    apb(1'b1, rpam_pkg::OFS_CTRL, 32'h0000_0301);
    chk("admin store data", 1, store_data);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read data");
    chk("unmapped error", 1, er);
    $display("test setup done");
  endtask
  task automatic t_good();
    int q, t, ex;
    build(16, 1'b0);
    run_event(16, 0, 1'b0, q, t);
    ex = t / 5 + 1 - 16;
    chk("quiet to drop in range", 1, q >= 75 && q <= 90);
    chk("activity length near", 1, act_len >= ex - 2 && act_len <= ex + 2);
    chk("check fail clean", 0, fcs_fail);
    chk("misalign clean", 0, misalign);
    chk("octet tally", 20, tally);
    chk("sender address", {frm[6], frm[7], frm[8], frm[9], frm[10], frm[11]}, sa);
    chk("sender address valid", 1, sa_valid);
    chk("no collision", 0, coll);
    rd_chk(rpam_pkg::OFS_STATUS, 32'h0000_0F00, 32'h0000_0300, "remembered port");
    $display("test good frame done");
  endtask
  task automatic t_bad();
    int q, t;
    build(16, 1'b1);
    run_event(16, 3, 1'b1, q, t);
    chk("check fail set", 1, fcs_fail);
    chk("misalign set", 1, misalign);
    chk("tally whole octets", 20, tally);
    chk("collision sticky", 1, coll);
    $display("test bad frame done");
  endtask
  task automatic t_next();
    int n;
    p.leave_idle(4'h3);
    @(posedge sys_clk);
    chk("carrier raised", 1, carrier);
    chk("collision cleared", 0, coll);
    chk("check fail cleared", 0, fcs_fail);
    chk("misalign cleared", 0, misalign);
    chk("tally cleared", 0, tally);
    chk("address invalid", 0, sa_valid);
    p.line(1'b1, 1'b0);
    n = 0;
    while (carrier !== 1'b0 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    chk("carrier dropped", 1, n < 500);
    chk("short event fails", 1, fcs_fail);
    $display("test next event done");
  endtask
  task automatic t_refuse();
    p.leave_idle(4'h5);
    p.line(1'b1, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk("other port ignored", 0, carrier);
    p.send_bits(8'hFF, 8);
    chk("bits without carrier", 0, tally);
    apb(1'b1, rpam_pkg::OFS_CTRL, 32'h0000_0300);
    chk("admin store cleared", 0, store_data);
    p.leave_idle(4'h3);
    p.line(1'b1, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk("disabled port ignored", 0, carrier);
    apb(1'b1, rpam_pkg::OFS_CTRL, 32'h0000_0301);
    $display("test refusals done");
  endtask
  task automatic t_counters();
    rd_chk(rpam_pkg::OFS_EVT_CNT, 32'hFFFF_FFFF, 32'h0000_0003, "event count");
    apb(1'b1, rpam_pkg::OFS_EVT_CNT, 32'h0000_0000);
    rd_chk(rpam_pkg::OFS_EVT_CNT, 32'hFFFF_FFFF, 32'h0000_0003, "event count kept");
    rd_chk(rpam_pkg::OFS_OCT_TOT, 32'hFFFF_FFFF, 32'h0000_0028, "octet total");
    rd_chk(rpam_pkg::OFS_FCS_CNT, 32'hFFFF_FFFF, 32'h0000_0002, "check fail count");
    chk("admin store writes", 3, n_store);
    $display("test counters done");
  endtask
  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_setup();
    t_good();
    t_bad();
    t_next();
    t_refuse();
    t_counters();
    results();
  end
endmodule
